// ==== logic/ers_consts.svh ====
// constants of the error rate test sequencer
`ifndef ERS_CONSTS_SVH
`define ERS_CONSTS_SVH

// ****************************************
// widths
// ****************************************
`define ERS_CNT_W        32
`define ERS_BS_W         13
`define ERS_SCALE_W      16
`define ERS_ITER_W       5
`define ERS_THR_W        8
`define ERS_PASS_W       8
`define ERS_ADDR_W       8
`define ERS_LFSR_W       16

// ****************************************
// register offsets
// ****************************************
`define ERS_OFF_STATUS   8'h00
`define ERS_OFF_MASK     8'h04
`define ERS_OFF_FAILBLK  8'h08
`define ERS_OFF_BLOCKS   8'h0c
`define ERS_OFF_BITERR   8'h10
`define ERS_OFF_PASSES   8'h14
`define ERS_OFF_STATE    8'h18
`define ERS_OFF_MAXBLK   8'h1c
`define ERS_OFF_MAXERR   8'h20

// ****************************************
// status / mask bit positions
// ****************************************
`define ERS_EV_DONE      0
`define ERS_EV_FAIL      1
`define ERS_EV_W         2

// ****************************************
// reset values and defaults
// ****************************************
`define ERS_MAXBLK_RST   32'h000003e8
`define ERS_MAXERR_RST   32'h00000064
`define ERS_LFSR_SEED    16'hace1
`define ERS_CHAN_LAT     4
`define ERS_MAX_BLOCK    5114

`endif

// ==== logic/ers_delay.sv ====
// fixed latency delay line for a handful of flag bits
`timescale 1ns/1ps
`include "ers_consts.svh"

module ers_delay #(
	parameter int WIDTH = 1,
	parameter int DEPTH = `ERS_CHAN_LAT
) (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst,
	// flag path
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	import ers_pkg::*;

	logic [DEPTH*WIDTH-1:0] pipe_reg;
	logic [DEPTH*WIDTH-1:0] pipe_next;

	// ****************************************
	// shift
	// ****************************************
	// a depth of one has no lower slice to shift, so it takes its own branch
	generate
		if (DEPTH > 1) begin : g_chain
			always_comb begin
				pipe_next = {pipe_reg[(DEPTH-1)*WIDTH-1:0], din};
			end
		end else begin : g_single
			always_comb begin
				pipe_next = din;
			end
		end
	endgenerate

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pipe_reg <= '0;
		end else begin
			pipe_reg <= pipe_next;
		end
	end

	assign dout = pipe_reg[DEPTH*WIDTH-1 -: WIDTH];

endmodule : ers_delay

// ==== logic/ers_pkg.sv ====
// types of the error rate test sequencer
`include "ers_consts.svh"

package ers_pkg;

	// ****************************************
	// sequencer states
	// ****************************************
	typedef enum logic [1:0] {
		ERS_IDLE = 2'b00,
		ERS_GEN  = 2'b01,
		ERS_DEC  = 2'b10,
		ERS_DONE = 2'b11
	} ers_state_e;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic [`ERS_BS_W-1:0]    block_size;
		logic [`ERS_ITER_W-1:0]  iterations;
		logic [`ERS_THR_W-1:0]   early_stop_threshold;
		logic [`ERS_SCALE_W-1:0] noise_scale;
		logic [`ERS_SCALE_W-1:0] dec_scale;
	} ers_params_s;

	typedef struct packed {
		logic [`ERS_CNT_W-1:0] failed_block_count;
		logic [`ERS_CNT_W-1:0] block_total;
		logic [`ERS_CNT_W-1:0] bit_error_total;
		logic [`ERS_CNT_W-1:0] decoder_pass_total;
	} ers_counts_s;

	typedef struct packed {
		ers_state_e              state;
		logic                    st_s1;
		logic                    st_s2;
		logic                    st_s3;
		logic                    nx_s1;
		logic                    nx_s2;
		logic                    nx_s3;
		ers_params_s             par_s1;
		ers_params_s             par_s2;
		ers_params_s             par;
		logic [`ERS_BS_W-1:0]    idx;
		logic [`ERS_LFSR_W-1:0]  lfsr;
		logic                    blk_err;
		ers_counts_s             cnt;
		logic                    point_done;
		logic                    enc_start;
		logic                    enc_valid;
		logic                    enc_bit;
		logic [`ERS_EV_W-1:0]    status;
		logic [`ERS_EV_W-1:0]    mask;
		logic [`ERS_CNT_W-1:0]   max_blocks;
		logic [`ERS_CNT_W-1:0]   max_errors;
		logic [31:0]             rdata;
	} ers_state_s;

endpackage : ers_pkg

// ==== logic/ers_sequencer.sv ====
// error rate test sequencer: block generation, compare, counters, stop, registers
`timescale 1ns/1ps
`include "ers_consts.svh"

module ers_sequencer #(
	parameter int MAX_BLOCK = `ERS_MAX_BLOCK,
	parameter int CHAN_LAT  = `ERS_CHAN_LAT
) (
	// clock and reset
	input  wire logic                     ref_clk,
	input  wire logic                     rst,
	// host link, asynchronous
	input  wire logic                     initial_start_pulse,
	input  wire logic                     next_point_request,
	input  wire ers_pkg::ers_params_s     host_params,
	output logic                          point_done,
	output ers_pkg::ers_counts_s          counts,
	// encoder side
	output logic                          enc_start,
	output logic                          enc_valid,
	output logic                          enc_bit,
	input  wire logic                     enc_rdy,
	// noise channel and decoder setup
	output ers_pkg::ers_params_s          core_params,
	// decoder side
	output logic                          dec_start,
	input  wire logic                     dec_valid,
	input  wire logic                     dec_bit,
	input  wire logic [`ERS_PASS_W-1:0]   dec_passes,
	// register port
	input  wire logic [`ERS_ADDR_W-1:0]   reg_addr,
	input  wire logic [31:0]              reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic [31:0]                   reg_rdata,
	// interrupt
	output logic                          irq
);
	import ers_pkg::*;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [`ERS_CNT_W-1:0] cnt_add(
		input logic [`ERS_CNT_W-1:0] a,
		input logic [`ERS_CNT_W-1:0] b
	);
		logic [`ERS_CNT_W:0] s;
		s = {1'b0, a} + {1'b0, b};
		// wrap rather than saturate; 32 bits outlast any sane run
		return s[`ERS_CNT_W-1:0];
	endfunction : cnt_add

	function automatic logic [`ERS_LFSR_W-1:0] lfsr_step(
		input logic [`ERS_LFSR_W-1:0] l
	);
		logic fb;
		fb = l[15] ^ l[13] ^ l[12] ^ l[10];
		return {l[`ERS_LFSR_W-2:0], fb};
	endfunction : lfsr_step

	// a length of zero or one beyond the compare memory would index past its end
	function automatic logic [`ERS_BS_W-1:0] fit_size(
		input logic [`ERS_BS_W-1:0] s
	);
		logic [`ERS_BS_W-1:0] r;
		r = s;
		if (s == '0) begin
			r = `ERS_BS_W'(1);
		end else if (s > `ERS_BS_W'(MAX_BLOCK)) begin
			r = `ERS_BS_W'(MAX_BLOCK);
		end
		return r;
	endfunction : fit_size

	// ****************************************
	// state
	// ****************************************
	ers_state_s st_reg;
	ers_state_s st_next;

	// original block bits, kept for the compare
	logic                           blk_mem [MAX_BLOCK];
	logic                           mem_we;
	logic [`ERS_BS_W-1:0]           mem_wa;
	logic                           mem_wd;
	logic                           mem_rd;

	logic                           start_edge;
	logic                           next_edge;
	logic                           start_ev;
	logic                           last_idx;
	logic                           mismatch;
	logic [`ERS_CNT_W-1:0]          new_blocks;
	logic [`ERS_CNT_W-1:0]          new_errors;
	logic [`ERS_EV_W-1:0]           ev;
	logic [`ERS_EV_W-1:0]           w1c;

	assign mem_rd   = blk_mem[st_reg.idx];
	assign last_idx = (st_reg.idx == st_reg.par.block_size - `ERS_BS_W'(1));
	assign mismatch = dec_valid && (dec_bit != mem_rd);

	// edge of either synchronised request; parameters were settled before it rose
	assign start_edge = st_reg.st_s2 & ~st_reg.st_s3;
	assign next_edge  = st_reg.nx_s2 & ~st_reg.nx_s3;
	assign start_ev   = start_edge | next_edge;

	always_comb begin
		st_next           = st_reg;
		st_next.enc_start = 1'b0;
		st_next.enc_valid = 1'b0;
		mem_we            = 1'b0;
		mem_wa            = st_reg.idx;
		mem_wd            = st_reg.lfsr[0];
		ev                = '0;
		w1c               = '0;
		new_blocks        = cnt_add(st_reg.cnt.block_total, `ERS_CNT_W'(1));
		new_errors        = cnt_add(st_reg.cnt.bit_error_total, `ERS_CNT_W'(mismatch));

		// two-flop synchronisers on the host handshake
		st_next.st_s1 = initial_start_pulse;
		st_next.st_s2 = st_reg.st_s1;
		st_next.st_s3 = st_reg.st_s2;
		st_next.nx_s1 = next_point_request;
		st_next.nx_s2 = st_reg.nx_s1;
		st_next.nx_s3 = st_reg.nx_s2;

		// ****************************************
		// host parameter capture
		// ****************************************
		// the parameter word takes the same two flops as the requests; the host
		// keeps it still across the handshake, so no bit is caught mid-change
		st_next.par_s1 = host_params;
		st_next.par_s2 = st_reg.par_s1;

		// ****************************************
		// sequencer
		// ****************************************
		unique case (st_reg.state)
			ERS_IDLE: begin
			end
			ERS_GEN: begin
				// random bits go to the encoder and into the compare memory
				mem_we            = 1'b1;
				st_next.enc_valid = 1'b1;
				st_next.enc_bit   = st_reg.lfsr[0];
				st_next.enc_start = (st_reg.idx == '0);
				st_next.lfsr      = lfsr_step(st_reg.lfsr);
				if (last_idx) begin
					st_next.idx   = '0;
					st_next.state = ERS_DEC;
				end else begin
					st_next.idx = st_reg.idx + `ERS_BS_W'(1);
				end
			end
			ERS_DEC: begin
				if (dec_valid) begin
					st_next.cnt.bit_error_total = new_errors;
					if (mismatch) begin
						st_next.blk_err = 1'b1;
					end
					if (last_idx) begin
						st_next.idx                     = '0;
						st_next.blk_err                 = 1'b0;
						st_next.cnt.block_total         = new_blocks;
						st_next.cnt.decoder_pass_total  = cnt_add(
							st_reg.cnt.decoder_pass_total,
							`ERS_CNT_W'(dec_passes));
						if (st_reg.blk_err || mismatch) begin
							st_next.cnt.failed_block_count = cnt_add(
								st_reg.cnt.failed_block_count,
								`ERS_CNT_W'(1));
							ev[`ERS_EV_FAIL] = 1'b1;
						end
						if ((new_blocks >= st_reg.max_blocks) ||
						    (new_errors >= st_reg.max_errors)) begin
							st_next.state      = ERS_DONE;
							st_next.point_done = 1'b1;
							ev[`ERS_EV_DONE]   = 1'b1;
						end else begin
							st_next.state = ERS_GEN;
						end
					end else begin
						st_next.idx = st_reg.idx + `ERS_BS_W'(1);
					end
				end
			end
			ERS_DONE: begin
				// held until the host asks for the next point
				st_next.point_done = 1'b1;
			end
		endcase

		// a new point overrides whatever the loop was doing
		if (start_ev) begin
			st_next.state      = ERS_GEN;
			st_next.par        = st_reg.par_s2;
			st_next.par.block_size = fit_size(st_reg.par_s2.block_size);
			st_next.idx        = '0;
			st_next.blk_err    = 1'b0;
			st_next.cnt        = '0;
			st_next.point_done = 1'b0;
		end

		// ****************************************
		// register writes
		// ****************************************
		if (reg_wr) begin
			unique case (reg_addr)
				`ERS_OFF_STATUS: w1c = reg_wdata[`ERS_EV_W-1:0];
				`ERS_OFF_MASK:   st_next.mask = reg_wdata[`ERS_EV_W-1:0];
				`ERS_OFF_MAXBLK: st_next.max_blocks = reg_wdata;
				`ERS_OFF_MAXERR: st_next.max_errors = reg_wdata;
				default: begin
				end
			endcase
		end
		// set wins over a clear in the same cycle
		st_next.status = (st_reg.status & ~w1c) | ev;

		// ****************************************
		// register reads, data in the next cycle
		// ****************************************
		st_next.rdata = '0;
		if (reg_rd) begin
			unique case (reg_addr)
				`ERS_OFF_STATUS:  st_next.rdata = 32'(st_reg.status);
				`ERS_OFF_MASK:    st_next.rdata = 32'(st_reg.mask);
				`ERS_OFF_FAILBLK: st_next.rdata = st_reg.cnt.failed_block_count;
				`ERS_OFF_BLOCKS:  st_next.rdata = st_reg.cnt.block_total;
				`ERS_OFF_BITERR:  st_next.rdata = st_reg.cnt.bit_error_total;
				`ERS_OFF_PASSES:  st_next.rdata = st_reg.cnt.decoder_pass_total;
				`ERS_OFF_STATE:   st_next.rdata = 32'({st_reg.point_done, st_reg.state});
				`ERS_OFF_MAXBLK:  st_next.rdata = st_reg.max_blocks;
				`ERS_OFF_MAXERR:  st_next.rdata = st_reg.max_errors;
				default:          st_next.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_reg            <= '0;
			st_reg.state      <= ERS_IDLE;
			st_reg.lfsr       <= `ERS_LFSR_SEED;
			st_reg.max_blocks <= `ERS_MAXBLK_RST;
			st_reg.max_errors <= `ERS_MAXERR_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// compare memory has no reset; every entry is written before it is read
	always_ff @(posedge ref_clk) begin
		if (mem_we) begin
			blk_mem[mem_wa] <= mem_wd;
		end
	end

	// ****************************************
	// channel latency match
	// ****************************************
	// the noise channel adds CHAN_LAT cycles, so the decoder start follows suit
	ers_delay #(
		.WIDTH (1),
		.DEPTH (CHAN_LAT)
	) u_rdy_delay (
		.ref_clk (ref_clk),
		.rst     (rst),
		.din     (enc_rdy),
		.dout    (dec_start)
	);

	// ****************************************
	// outputs
	// ****************************************
	assign core_params = st_reg.par;
	assign enc_start   = st_reg.enc_start;
	assign enc_valid   = st_reg.enc_valid;
	assign enc_bit     = st_reg.enc_bit;
	assign point_done  = st_reg.point_done;
	assign counts      = st_reg.cnt;
	assign reg_rdata   = st_reg.rdata;
	assign irq         = |(st_reg.status & st_reg.mask);

endmodule : ers_sequencer

// ==== tb/ers_codec_model.sv ====
// behavioural encoder, noise channel and decoder stand-in
`timescale 1ns/1ps

module ers_codec_model (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// encoder side
	input  wire logic       enc_valid,
	input  wire logic       enc_bit,
	output logic            enc_rdy,
	// decoder side
	input  wire logic       dec_start,
	input  wire logic [7:0] flip,
	output logic            dec_valid,
	output logic            dec_bit
);
	logic q[$];
	logic ds_reg;
	logic busy;
	int   k;
	// ********
	// replay the block once the delayed ready has passed
	// ********
	always @(posedge ref_clk) begin
		if (rst) begin
			q.delete();
			{enc_rdy, ds_reg, busy, dec_valid, dec_bit} <= '0;
			k = 0;
		end else begin
			enc_rdy <= enc_valid;
			ds_reg <= dec_start;
			if (enc_valid) q.push_back(enc_bit);
			dec_valid <= 1'b0;
			// idle line toggles so a stale bit never passes for data
			dec_bit <= ~dec_bit;
			if (busy && q.size() > 0) begin
				dec_valid <= 1'b1;
				dec_bit <= q.pop_front() ^ flip[k];
				k = k + 1;
			end else busy <= 1'b0;
			if (ds_reg && !dec_start) begin
				busy <= 1'b1;
				k = 0;
			end
		end
	end
endmodule : ers_codec_model

// ==== tb/ers_seq_sva.sv ====
// assertions on the ports of the error rate test sequencer
`timescale 1ns/1ps
`include "ers_consts.svh"

module ers_seq_sva #(
	parameter int MAX_BLOCK = `ERS_MAX_BLOCK,
	parameter int CHAN_LAT  = `ERS_CHAN_LAT
) (
	// clock and reset
	input wire logic                 ref_clk,
	input wire logic                 rst,
	// host link
	input wire logic                 initial_start_pulse,
	input wire logic                 next_point_request,
	input wire logic                 point_done,
	input wire ers_pkg::ers_counts_s counts,
	input wire ers_pkg::ers_params_s core_params,
	// codec side
	input wire logic                 enc_start,
	input wire logic                 enc_valid,
	input wire logic                 enc_rdy,
	input wire logic                 dec_start
);
	import ers_pkg::*;
	// ********
	// helpers
	// ********
	logic [5:0]           req_hist_reg;
	logic [`ERS_BS_W-1:0] run_reg;
	always_ff @(posedge ref_clk) begin
		req_hist_reg <= {req_hist_reg[4:0], initial_start_pulse | next_point_request};
		run_reg      <= enc_valid ? run_reg + 1'b1 : '0;
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	// ********
	// checks
	// ********
	a_start_clears: assert property (
		$rose(initial_start_pulse | next_point_request) |-> ##[5:6] (counts == '0 && !point_done))
		else $error("counters or done not cleared by start");
	a_done_holds: assert property (
		point_done && req_hist_reg == '0 && !initial_start_pulse && !next_point_request
		|=> point_done) else $error("point done dropped without a start");
	a_stop_idle: assert property (
		point_done |-> !enc_valid && !enc_start) else $error("block sent after stop");
	a_first_bit: assert property (
		enc_start == $rose(enc_valid)) else $error("block start mark not on first bit");
	a_enc_len: assert property (
		$fell(enc_valid) |-> run_reg == core_params.block_size)
		else $error("encoder run length differs from block size");
	a_dec_delay: assert property (
		dec_start == $past(enc_rdy, CHAN_LAT)) else $error("decoder start not delayed ready");
	a_blk_step: assert property (
		$changed(counts.block_total)
		|-> counts.block_total == $past(counts.block_total) + 1 || counts.block_total == '0)
		else $error("block total jumped");
	a_fail_with_blk: assert property (
		$changed(counts.failed_block_count) |-> $changed(counts.block_total))
		else $error("failed count moved alone");
	a_err_step: assert property (
		$changed(counts.bit_error_total)
		|-> counts.bit_error_total == $past(counts.bit_error_total) + 1
		|| counts.bit_error_total == '0)
		else $error("bit error count jumped");
	a_pass_with_blk: assert property (
		$changed(counts.decoder_pass_total) |-> $changed(counts.block_total))
		else $error("pass total moved alone");
endmodule : ers_seq_sva

bind ers_sequencer ers_seq_sva #(.MAX_BLOCK(MAX_BLOCK), .CHAN_LAT(CHAN_LAT)) u_sva (
	.ref_clk, .rst, .initial_start_pulse, .next_point_request, .point_done, .counts,
	.core_params, .enc_start, .enc_valid, .enc_rdy, .dec_start);

// ==== tb/tb_top.sv ====
// self-checking bench for the error rate test sequencer
`timescale 1ns/1ps
`include "ers_consts.svh"

module tb_top;
	import ers_pkg::*;
	typedef struct packed {
		logic [7:0] bs, flip, passes, maxb, maxe, blk, fail, err;
	} ers_row_s;
	localparam ers_row_s ROWS [4] = '{
		'{8'h08, 8'h00, 8'h03, 8'h03, 8'h64, 8'h03, 8'h00, 8'h00},
		'{8'h08, 8'h05, 8'h02, 8'h03, 8'h64, 8'h03, 8'h03, 8'h06},
		'{8'h08, 8'h01, 8'h07, 8'h64, 8'h01, 8'h01, 8'h01, 8'h01},
		'{8'h05, 8'h10, 8'h01, 8'h02, 8'h64, 8'h02, 8'h02, 8'h02}};
	logic        ref_clk = 0;
	logic        rst = 1;
	logic        initial_start_pulse = 0;
	logic        next_point_request = 0;
	logic        reg_wr = 0;
	logic        reg_rd = 0;
	logic        point_done, enc_start, enc_valid, enc_bit, enc_rdy, dec_start;
	logic        dec_valid, dec_bit, irq;
	logic [7:0]  dec_passes = '0, reg_addr = '0, flip = '0;
	logic [31:0] reg_wdata = '0, reg_rdata, rd_val;
	ers_params_s host_params = '0;
	ers_params_s core_params;
	ers_counts_s counts;
	int          fail_count = 0;
	int          checked = 0;
	always #5 ref_clk = ~ref_clk;

	ers_sequencer #(.CHAN_LAT(4)) uut (.ref_clk, .rst, .initial_start_pulse,
		.next_point_request, .host_params, .point_done, .counts, .enc_start, .enc_valid,
		.enc_bit, .enc_rdy, .core_params, .dec_start, .dec_valid, .dec_bit, .dec_passes,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
	ers_codec_model u_codec (.ref_clk, .rst, .enc_valid, .enc_bit, .enc_rdy, .dec_start,
		.flip, .dec_valid, .dec_bit);

	// ********
	// tasks
	// ********
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : reg_write
	task automatic reg_read(input logic [7:0] a);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rdata;
	endtask : reg_read
	task automatic run_point(input logic use_next);
		int n;
		@(posedge ref_clk);
		if (use_next) next_point_request <= 1'b1;
		else initial_start_pulse <= 1'b1;
		repeat (3) @(posedge ref_clk);
		{initial_start_pulse, next_point_request} <= 2'b00;
		repeat (4) @(posedge ref_clk);
		#1 check("done low", point_done, 1'b0);
		check("params", {31'h0, core_params == host_params}, 32'h1);
		check("noise scale", 32'(core_params.noise_scale), 32'(host_params.noise_scale));
		n = 0;
		while (point_done !== 1'b1 && n < 5000) begin
			@(posedge ref_clk);
			n++;
		end
		#1 check("done", point_done, 1'b1);
	endtask : run_point
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : tally_and_finish

	initial begin
		#200000;
		fail_count++;
		tally_and_finish();
	end

	initial begin
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		foreach (ROWS[i]) begin
			@(posedge ref_clk);
			host_params <= {5'h00, ROWS[i].bs, 5'h03, ROWS[i].passes,
				8'h11, ROWS[i].flip, ROWS[i].flip, 8'h22};
			flip <= ROWS[i].flip;
			dec_passes <= ROWS[i].passes;
			reg_write(8'h00, 32'h3);
			reg_write(8'h1c, {24'h0, ROWS[i].maxb});
			reg_write(8'h20, {24'h0, ROWS[i].maxe});
			run_point(i[0]);
			check("blocks", counts.block_total, ROWS[i].blk);
			check("failed", counts.failed_block_count, ROWS[i].fail);
			check("biterr", counts.bit_error_total, ROWS[i].err);
			check("passes", counts.decoder_pass_total, ROWS[i].blk * ROWS[i].passes);
			reg_read(8'h0c);
			check("blocks reg", rd_val, ROWS[i].blk);
			reg_read(8'h00);
			check("status", rd_val, {ROWS[i].fail != 0, 1'b1});
			check("done held", point_done, 1'b1);
		end
		// interrupt: unmask the done event, then clear it and keep the failed event
		reg_write(8'h04, 32'h1);
		@(posedge ref_clk);
		#1 check("irq on", irq, 1'b1);
		reg_write(8'h00, 32'h1);
		@(posedge ref_clk);
		#1 check("irq off", irq, 1'b0);
		reg_read(8'h00);
		check("status w1c", rd_val, 32'h2);
		// refused accesses: unmapped read, write to a read-only counter
		reg_read(8'h40);
		check("unmapped", rd_val, 32'h0);
		reg_write(8'h0c, 32'h55);
		reg_read(8'h0c);
		check("ro blocks", rd_val, ROWS[3].blk);
		// second reset while the last point is done
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		reg_read(8'h1c);
		check("maxblk rst", rd_val, `ERS_MAXBLK_RST);
		reg_read(8'h20);
		check("maxerr rst", rd_val, `ERS_MAXERR_RST);
		reg_read(8'h04);
		check("mask rst", rd_val, 32'h0);
		check("done rst", point_done, 1'b0);
		check("count rst", counts.block_total, 32'h0);
		tally_and_finish();
	end
endmodule : tb_top
